// [src/gate_driver_fault_protection.sv]
// fault supervision of a three-phase gate driver with apb registers
`timescale 1ns/1ns
`default_nettype none
`include "gdrv_fault_map.svh"
module gate_driver_fault_protection #(
    parameter bit PIN_CONFIG = 1'b0,
    parameter int RETRY_CYCLES = `GDF_RETRY_MS * 1000 * `GDF_CLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic motor_supply_uv,
    input wire logic drain_sense_supply_uv,
    input wire logic charge_pump_rail_uv,
    input wire logic low_side_gate_rail_uv,
    input wire logic [5:0] vds_over,
    input wire logic [5:0] pwm_in,
    input wire logic threshold_config_pin,
    input wire logic enable_reset_pulse,
    output logic [5:0] gate_enable,
    output logic charge_pump_en,
    output logic fault_out_n,
    output logic [3:0] drain_source_threshold_select,
    output logic irq
);
    localparam int DEG_W = 8;

    function automatic logic [DEG_W-1:0] ns_to_cycles(input int ns);
        int c;
        c = (ns * `GDF_CLK_MHZ + 999) / 1000;
        if (c < 1) begin
            c = 1;
        end
        return DEG_W'(c);
    endfunction

    function automatic logic [DEG_W-1:0] deg_limit(input logic [1:0] sel);
        logic [DEG_W-1:0] r;
        r = ns_to_cycles(`GDF_DEG0_NS);
        case (sel)
            2'h0: r = ns_to_cycles(`GDF_DEG0_NS);
            2'h1: r = ns_to_cycles(`GDF_DEG1_NS);
            2'h2: r = ns_to_cycles(`GDF_DEG2_NS);
            2'h3: r = ns_to_cycles(`GDF_DEG3_NS);
            default: r = ns_to_cycles(`GDF_DEG0_NS);
        endcase
        return r;
    endfunction

    // pins come from analog comparators and the controller: two flops first
    gdrv_fault_pkg::pins_t pin_raw;
    gdrv_fault_pkg::pins_t sync1_q;
    gdrv_fault_pkg::pins_t sync2_q;
    logic [5:0] pwm_prev_q;

    assign pin_raw = '{
        motor_supply_uv: motor_supply_uv,
        drain_sense_supply_uv: drain_sense_supply_uv,
        charge_pump_rail_uv: charge_pump_rail_uv,
        low_side_gate_rail_uv: low_side_gate_rail_uv,
        threshold_config_pin: threshold_config_pin,
        enable_reset_pulse: enable_reset_pulse,
        pwm: pwm_in,
        vds_over: vds_over
    };

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            // all ones only while in reset; sync2_q.pwm resets to zero, so the first synced high pwm value after reset is a rising edge
            pwm_prev_q <= '1;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            pwm_prev_q <= sync2_q.pwm;
        end
    end

    // register state
    gdrv_fault_pkg::ctrl_t ctrl_q;
    gdrv_fault_pkg::status_t status;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [31:0] prdata_q;
    logic clear_pulse_q;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    assign addr_ok = (paddr == `GDF_OFF_STATUS) || (paddr == `GDF_OFF_CTRL)
        || (paddr == `GDF_OFF_IRQ_STAT) || (paddr == `GDF_OFF_IRQ_MASK);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= gdrv_fault_pkg::ctrl_t'(`GDF_CTRL_RESET); // [RULE11]
        end else if (wr_en && paddr == `GDF_OFF_CTRL) begin
            ctrl_q <= gdrv_fault_pkg::ctrl_t'(pwdata & `GDF_CTRL_WMASK); // [RULE17]
        end
    end

    // fault clear is a one-cycle command; it never lands in ctrl_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_pulse_q <= 1'b0;
        end else begin
            clear_pulse_q <= (wr_en && paddr == `GDF_OFF_CTRL && pwdata[0])
                || sync2_q.enable_reset_pulse; // [RULE17] [RULE3]
        end
    end

    // effective configuration; pin variant overrides the register fields except drain_source_threshold_select
    logic gd_check_on;
    logic ocp_disabled;
    gdrv_fault_pkg::overcurrent_response_select_t mode;
    logic per_cycle;
    logic linked;
    logic [DEG_W-1:0] deg_cnt_max;
    assign gd_check_on = PIN_CONFIG || !ctrl_q.gate_supply_check_disable; // [RULE6]
    assign mode = PIN_CONFIG ? gdrv_fault_pkg::ocp_retry
        : ctrl_q.overcurrent_response_select; // [RULE8] [RULE9]
    assign ocp_disabled = (mode == gdrv_fault_pkg::ocp_off)
        || (PIN_CONFIG && sync2_q.threshold_config_pin); // [RULE15] [RULE8]
    assign per_cycle = PIN_CONFIG || ctrl_q.per_cycle_clear_mode; // [RULE10]
    assign linked = !PIN_CONFIG && ctrl_q.overcurrent_link_select; // [RULE11]
    assign deg_cnt_max = PIN_CONFIG ? ns_to_cycles(`GDF_HW_DEG_NS)
        : deg_limit(ctrl_q.overcurrent_deglitch_select); // [RULE8] [RULE9]
    assign drain_source_threshold_select = ctrl_q.drain_source_threshold_select;

    // live undervoltage levels
    logic supply_uv_live;
    logic gate_uv_live;
    assign supply_uv_live = sync2_q.motor_supply_uv || sync2_q.drain_sense_supply_uv;
    assign gate_uv_live = gd_check_on
        && (sync2_q.charge_pump_rail_uv || sync2_q.low_side_gate_rail_uv); // [RULE4]

    // sticky undervoltage flags, set wins over clear
    logic uv_flag_q;
    logic gd_flag_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_flag_q <= 1'b0;
            gd_flag_q <= 1'b0;
        end else begin
            if (supply_uv_live) begin
                uv_flag_q <= 1'b1; // [RULE2]
            end else if (clear_pulse_q) begin
                uv_flag_q <= 1'b0; // [RULE3]
            end
            if (gate_uv_live) begin
                gd_flag_q <= 1'b1; // [RULE4]
            end else if (clear_pulse_q) begin
                gd_flag_q <= 1'b0; // [RULE5]
            end
        end
    end

    // per-MOSFET deglitch: only a comparator on a driven MOSFET counts
    logic [DEG_W-1:0] deg_q [6];
    logic [5:0] ocp_hit;
    logic [5:0] armed;
    assign armed = sync2_q.vds_over & sync2_q.pwm & gate_enable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 6; i++) begin
                deg_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (!armed[i]) begin
                    deg_q[i] <= '0; // [RULE7]
                end else if (deg_q[i] != deg_cnt_max) begin
                    deg_q[i] <= deg_q[i] + DEG_W'(1);
                end
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            ocp_hit[i] = armed[i] && (deg_q[i] == deg_cnt_max) && !ocp_disabled; // [RULE7]
        end
    end

    // retry timer for mode 01
    gdrv_fault_pkg::retry_state_t rst_q;
    logic [31:0] retry_cnt_q;
    logic retry_expire;
    logic [5:0] ocp_q;
    assign retry_expire = (rst_q == gdrv_fault_pkg::retry_done);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q <= gdrv_fault_pkg::retry_idle;
            retry_cnt_q <= '0;
        end else begin
            case (rst_q)
                gdrv_fault_pkg::retry_idle: begin
                    retry_cnt_q <= '0;
                    if (|ocp_q && mode == gdrv_fault_pkg::ocp_retry) begin
                        rst_q <= gdrv_fault_pkg::retry_wait;
                    end
                end
                gdrv_fault_pkg::retry_wait: begin
                    retry_cnt_q <= retry_cnt_q + 32'h1;
                    if (!(|ocp_q) || mode != gdrv_fault_pkg::ocp_retry) begin
                        rst_q <= gdrv_fault_pkg::retry_idle;
                    end else if (retry_cnt_q >= 32'(RETRY_CYCLES - 2)) begin
                        rst_q <= gdrv_fault_pkg::retry_done; // [RULE13]
                    end
                end
                default: begin
                    rst_q <= gdrv_fault_pkg::retry_idle;
                end
            endcase
        end
    end

    // overcurrent flags: a new hit beats any clear in the same cycle
    logic pwm_rise;
    logic manual_clear;
    assign pwm_rise = |(sync2_q.pwm & ~pwm_prev_q);
    assign manual_clear = clear_pulse_q
        && (mode == gdrv_fault_pkg::ocp_latched || mode == gdrv_fault_pkg::ocp_report);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ocp_q <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (ocp_hit[i]) begin
                    ocp_q[i] <= 1'b1; // [RULE12] [RULE13] [RULE14]
                end else if (ocp_disabled) begin
                    ocp_q[i] <= 1'b0; // [RULE15]
                end else if (manual_clear && !sync2_q.vds_over[i]) begin
                    ocp_q[i] <= 1'b0; // [RULE12] [RULE14]
                end else if (retry_expire) begin
                    ocp_q[i] <= 1'b0; // [RULE13]
                end else if (per_cycle && pwm_rise) begin
                    ocp_q[i] <= 1'b0; // [RULE10]
                end
            end
        end
    end

    // gate shutdown; report mode keeps switching, controller must react
    logic shut_mode;
    logic [2:0] hb_trip;
    logic [5:0] ocp_off_gates;
    assign shut_mode = (mode == gdrv_fault_pkg::ocp_latched)
        || (mode == gdrv_fault_pkg::ocp_retry); // [RULE14] [RULE16]
    always_comb begin
        for (int h = 0; h < 3; h++) begin
            hb_trip[h] = ocp_q[2*h] || ocp_q[2*h+1];
        end
        for (int h = 0; h < 3; h++) begin
            ocp_off_gates[2*h] = shut_mode && (linked ? |hb_trip : hb_trip[h]); // [RULE11]
            ocp_off_gates[2*h+1] = ocp_off_gates[2*h];
        end
    end

    logic uv_block;
    assign uv_block = supply_uv_live || gate_uv_live; // [RULE1] [RULE4]
    assign gate_enable = uv_block ? 6'h00 : ~ocp_off_gates; // [RULE12] [RULE13]
    assign charge_pump_en = !supply_uv_live; // [RULE1]

    // fault pin follows live conditions and latched overcurrent; global flag also holds while a sticky undervoltage flag is set
    logic fault_now;
    logic fault_q;
    assign fault_now = uv_block || (|ocp_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_now; // [RULE2] [RULE5] [RULE12]
        end
    end
    assign fault_out_n = !fault_now; // [RULE1] [RULE4] [RULE14]

    assign status = '{
        rsvd: '0,
        mosfet_overcurrent: ocp_q,
        drain_source_overcurrent_flag: |ocp_q,
        gate_supply_undervolt_flag: gd_flag_q,
        supply_undervolt_flag: uv_flag_q,
        fault: fault_q || uv_flag_q || gd_flag_q
    };

    // interrupt events: rising edges of the three flags
    logic [2:0] ev_q;
    logic [2:0] ev_now;
    assign ev_now = {|ocp_q, gd_flag_q, uv_flag_q};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_q <= '0;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            ev_q <= ev_now;
            // a new event wins over a write-one-to-clear
            if (wr_en && paddr == `GDF_OFF_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | (ev_now & ~ev_q);
            end else begin
                irq_stat_q <= irq_stat_q | (ev_now & ~ev_q);
            end
            if (wr_en && paddr == `GDF_OFF_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // read data captured in the setup cycle, held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            case (paddr)
                `GDF_OFF_STATUS: prdata_q <= status;
                `GDF_OFF_CTRL: prdata_q <= ctrl_q; // [RULE17]
                `GDF_OFF_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
                `GDF_OFF_IRQ_MASK: prdata_q <= {29'h0, irq_mask_q};
                default: prdata_q <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// [src/gdrv_fault_map.svh]
// register map, field positions, reset values and timing for fault supervision
// Functional notes
// RULE1: supply undervoltage: gates off, pump off, fault low
// RULE2: supply undervoltage latches flags, recovers automatically
// RULE3: supply flag held until clear or enable pulse
// RULE4: gate rail undervoltage: gates off, fault, flags
// RULE5: gate rail flag sticky; driving resumes automatically
// RULE6: gate rail check disable bit, pin variant always
// RULE7: overcurrent needs enabled MOSFET beyond deglitch time
// RULE8: pin variant: 4us deglitch, 8ms retry, tie-off
// RULE9: register threshold, deglitch, four response modes
// RULE10: per-cycle mode: PWM rising edge clears overcurrent
// RULE11: link select default 0; 1 links bridges
// RULE12: mode 00 latched shutdown until clear
// RULE13: mode 01 retry period clears automatically
// RULE14: mode 10 reports only, gates keep running
// RULE15: mode 11 ignores overcurrent entirely
// RULE16: report mode leaves overcurrent handling to controller
// RULE17: fault clear bit self-clears, reads zero
`ifndef GDRV_FAULT_MAP_SVH
`define GDRV_FAULT_MAP_SVH
`define GDF_OFF_STATUS 12'h000
`define GDF_OFF_CTRL 12'h004
`define GDF_OFF_IRQ_STAT 12'h008
`define GDF_OFF_IRQ_MASK 12'h00c
`define GDF_CTRL_RESET 32'h0000_0014
`define GDF_CTRL_WMASK 32'h0000_0ffe
`define GDF_IRQ_BITS 3
`define GDF_CLK_MHZ 20
`define GDF_HW_DEG_NS 4000
`define GDF_DEG0_NS 1000
`define GDF_DEG1_NS 2000
`define GDF_DEG2_NS 4000
`define GDF_DEG3_NS 8000
`define GDF_RETRY_MS 8
`endif

// [src/gdrv_fault_pkg.sv]
// types shared by the gate driver fault supervision logic
package gdrv_fault_pkg;
    typedef enum logic [1:0] {
        ocp_latched = 2'b00,
        ocp_retry = 2'b01,
        ocp_report = 2'b10,
        ocp_off = 2'b11
    } overcurrent_response_select_t;

    // bit 0 fault_clear_bit, read back as zero
    typedef struct packed {
        logic [19:0] rsvd;
        logic [3:0] drain_source_threshold_select;
        logic [1:0] overcurrent_deglitch_select;
        overcurrent_response_select_t overcurrent_response_select;
        logic overcurrent_link_select;
        logic per_cycle_clear_mode;
        logic gate_supply_check_disable;
        logic fault_clear_bit;
    } ctrl_t;

    typedef struct packed {
        logic [21:0] rsvd;
        logic [5:0] mosfet_overcurrent;
        logic drain_source_overcurrent_flag;
        logic gate_supply_undervolt_flag;
        logic supply_undervolt_flag;
        logic fault;
    } status_t;

    typedef struct packed {
        logic motor_supply_uv;
        logic drain_sense_supply_uv;
        logic charge_pump_rail_uv;
        logic low_side_gate_rail_uv;
        logic threshold_config_pin;
        logic enable_reset_pulse;
        logic [5:0] pwm;
        logic [5:0] vds_over;
    } pins_t;

    typedef enum logic [1:0] {
        retry_idle = 2'b00,
        retry_wait = 2'b01,
        retry_done = 2'b11
    } retry_state_t;
endpackage

// [sim/motor_ctrl_model.sv]
// controller model: drives the pwm inputs, backs off in report mode
`timescale 1ns/1ns
`default_nettype none
module motor_ctrl_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic blip,
    input wire logic report_mode,
    input wire logic fault_out_n,
    output logic [5:0] pwm_in
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_in <= 6'h3f;
        end else if (report_mode && !fault_out_n) begin
            pwm_in <= 6'h00; // gates keep switching, so we stop them ourselves
        end else begin
            pwm_in <= blip ? 6'h00 : 6'h3f;
        end
    end
endmodule
`default_nettype wire

// [sim/gdrv_fault_chk.sv]
// checker for the gate driver fault supervision ports
`timescale 1ns/1ns
`default_nettype none
module gdrv_fault_chk #(
    parameter int RETRY_CYCLES = 160000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic motor_supply_uv,
    input wire logic drain_sense_supply_uv,
    input wire logic charge_pump_rail_uv,
    input wire logic low_side_gate_rail_uv,
    input wire logic [5:0] vds_over,
    input wire logic [5:0] pwm_in,
    input wire logic [5:0] gate_enable,
    input wire logic charge_pump_en,
    input wire logic fault_out_n,
    input wire logic [3:0] drain_source_threshold_select
);
    gdrv_fault_pkg::ctrl_t ctl_q;
    logic [2:0] quiet_q;
    int low_q;
    wire logic any_uv = motor_supply_uv | drain_sense_supply_uv | charge_pump_rail_uv
        | low_side_gate_rail_uv;
    wire logic [1:0] mode = ctl_q.overcurrent_response_select;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 32'h0000_0014;
        end else if (psel && penable && pwrite && paddr == 12'h004) begin
            ctl_q <= pwdata;
        end
    end
    // uv inputs low long enough for the sync stages to have drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 3'h0;
        end else begin
            quiet_q <= any_uv ? 3'h0 : (quiet_q == 3'h7 ? 3'h7 : quiet_q + 3'h1);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 0;
        end else begin
            low_q <= (fault_out_n || mode != 2'h1 || quiet_q != 3'h7) ? 0 : low_q + 1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_UV_OFF: assert property ((motor_supply_uv || drain_sense_supply_uv) [*4] |->
        gate_enable == 6'h00 && !charge_pump_en && !fault_out_n) else $error("uv not shut");
    AST_PUMP_BACK: assert property ((!motor_supply_uv && !drain_sense_supply_uv) [*4] |->
        charge_pump_en) else $error("pump not back");
    AST_GATE_SUPPLY_UNDERVOLT_FLAG_OFF: assert property ((charge_pump_rail_uv || low_side_gate_rail_uv) [*4]
        ##0 !ctl_q.gate_supply_check_disable |-> !fault_out_n && gate_enable == 6'h00)
        else $error("gate uv not shut");
    AST_OFF_QUIET: assert property (mode == 2'h3 && $stable(ctl_q) && quiet_q == 3'h7 |->
        fault_out_n && gate_enable == 6'h3f) else $error("mode off acted");
    AST_REPORT_RUNS: assert property (mode == 2'h2 && quiet_q == 3'h7 |->
        gate_enable == 6'h3f) else $error("report mode stopped gates");
    AST_DEGLITCH: assert property (quiet_q == 3'h7 && $fell(fault_out_n) |->
        $past(|(vds_over & pwm_in), 20)) else $error("trip before deglitch");
    AST_LINK: assert property (quiet_q == 3'h7 && !fault_out_n && mode < 2'h2 |->
        (ctl_q.overcurrent_link_select ? gate_enable == 6'h00 : $countones(gate_enable) == 4))
        else $error("link response wrong");
    AST_RETRY_MAX: assert property (low_q <= RETRY_CYCLES + 2)
        else $error("retry too late");
    AST_RETRY_MIN: assert property ($rose(fault_out_n) && quiet_q == 3'h7 && $past(low_q) != 0
        |-> $past(low_q) >= RETRY_CYCLES - 2) else $error("retry too early");
    AST_THRESH: assert property (psel && penable && pwrite && paddr == 12'h004 |=>
        drain_source_threshold_select == $past(pwdata[11:8])) else $error("threshold wrong");
    cover property (mode == 2'h1 && $rose(fault_out_n));
    cover property (mode == 2'h2 && $fell(fault_out_n));
    cover property (ctl_q.per_cycle_clear_mode && quiet_q == 3'h7 && $rose(fault_out_n));
endmodule
bind gate_driver_fault_protection gdrv_fault_chk #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (.*);
`default_nettype wire

// [sim/gate_driver_fault_protection_tb.sv]
// self-checking bench for the gate driver fault supervision block
`timescale 1ns/1ns
`default_nettype none
`include "gdrv_fault_map.svh"
module gate_driver_fault_protection_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, blip = 1'b0, report_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, e;
    logic pready, pslverr, s, charge_pump_en, fault_out_n, irq;
    logic motor_supply_uv = 1'b0, drain_sense_supply_uv = 1'b0, enable_reset_pulse = 1'b0;
    logic charge_pump_rail_uv = 1'b0, low_side_gate_rail_uv = 1'b0, threshold_config_pin = 1'b0;
    logic [5:0] vds_over = 6'h00, pwm_in, gate_enable;
    logic [3:0] drain_source_threshold_select;
    int num_errors = 0, comparisons = 0, cyc = 0;
    // {ctrl byte, gate_enable, status, released after wait}
    logic [31:0] rows [6] = '{32'h0800_1900, 32'h1800_1901, 32'h283f_1900,
        32'h383f_0001, 32'h003c_1900, 32'h0c00_1901};
    always #25 pclk = ~pclk;
    gate_driver_fault_protection #(.PIN_CONFIG(1'b0), .RETRY_CYCLES(50)) uut (.*);
    motor_ctrl_model ctl (.*);
    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // {fault_out_n, charge_pump_en, gate_enable}; back on a rising edge so later drives stay there
    task automatic pins(input logic [7:0] exp);
        @(negedge pclk);
        chk({24'h0, fault_out_n, charge_pump_en, gate_enable}, {24'h0, exp});
        @(posedge pclk);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`GDF_OFF_CTRL, 32'h14);
        rd(12'h010, 32'h0);
        chk({31'h0, s}, 32'h1);
        apb(1'b1, `GDF_OFF_IRQ_MASK, 32'h5);
        motor_supply_uv <= 1'b1;
        repeat (5) @(posedge pclk);
        pins(8'h00);
        chk({31'h0, irq}, 32'h1);
        rd(`GDF_OFF_STATUS, 32'h3);
        motor_supply_uv <= 1'b0;
        repeat (5) @(posedge pclk);
        pins(8'hff);
        rd(`GDF_OFF_STATUS, 32'h3);
        apb(1'b1, `GDF_OFF_CTRL, 32'h15);
        apb(1'b1, `GDF_OFF_IRQ_STAT, 32'h7);
        rd(`GDF_OFF_STATUS, 32'h0);
        rd(`GDF_OFF_CTRL, 32'h14);
        chk({31'h0, irq}, 32'h0);
        charge_pump_rail_uv <= 1'b1;
        repeat (5) @(posedge pclk);
        pins(8'h40);
        charge_pump_rail_uv <= 1'b0;
        repeat (5) @(posedge pclk);
        pins(8'hff);
        rd(`GDF_OFF_STATUS, 32'h5);
        rd(`GDF_OFF_IRQ_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        enable_reset_pulse <= 1'b1;
        repeat (4) @(posedge pclk);
        enable_reset_pulse <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(`GDF_OFF_STATUS, 32'h0);
        apb(1'b1, `GDF_OFF_CTRL, 32'h16);
        low_side_gate_rail_uv <= 1'b1;
        repeat (5) @(posedge pclk);
        pins(8'hff);
        rd(`GDF_OFF_STATUS, 32'h0);
        low_side_gate_rail_uv <= 1'b0;
        apb(1'b1, `GDF_OFF_CTRL, 32'h08);
        vds_over <= 6'h01;
        repeat (10) @(posedge pclk);
        vds_over <= 6'h00;
        repeat (30) @(posedge pclk);
        pins(8'hff);
        foreach (rows[i]) begin
            e = rows[i];
            report_mode <= (e[31:28] == 4'h2);
            apb(1'b1, `GDF_OFF_CTRL, {20'h0, 4'ha, e[31:24]});
            vds_over <= 6'h01;
            repeat (30) @(posedge pclk);
            pins({e[15:8] == 8'h00, 1'b1, e[21:16]});
            rd(`GDF_OFF_STATUS, {24'h0, e[15:8]});
            vds_over <= 6'h00;
            blip <= 1'b1;
            @(posedge pclk);
            blip <= 1'b0;
            repeat (80) @(posedge pclk);
            pins({e[0], 1'b1, e[0] ? 6'h3f : e[21:16]});
            apb(1'b1, `GDF_OFF_CTRL, {20'h0, 4'ha, e[31:24] | 8'h01});
            repeat (3) @(posedge pclk);
            pins(8'hff);
            rd(`GDF_OFF_STATUS, 32'h0);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
